// ---- pkg/lsodt_pkg.sv ----
`default_nettype none
package lsodt_pkg;

  // Operation class reported for each decoded instruction
  typedef enum logic [3:0] {
    OP_ILLEGAL, OP_AND, OP_TEST, OP_OR, OP_XOR, OP_NOT,
    OP_SCMP, OP_PIN, OP_SLOAD, OP_SCOPY, OP_POUT, OP_SSCAN, OP_SSTORE
  } lsodt_op_t;

  // Upper seven opcode bits; bit 0 is size_full
  localparam logic [6:0] OPC_AND_RM   = 7'h10; // 0010000w
  localparam logic [6:0] OPC_AND_MR   = 7'h11; // 0010001w
  localparam logic [6:0] OPC_AND_ACC  = 7'h12; // 0010010w
  localparam logic [6:0] OPC_OR_RM    = 7'h04; // 0000100w
  localparam logic [6:0] OPC_OR_MR    = 7'h05; // 0000101w
  localparam logic [6:0] OPC_OR_ACC   = 7'h06; // 0000110w
  localparam logic [6:0] OPC_XOR_RM   = 7'h18; // 0011000w
  localparam logic [6:0] OPC_XOR_MR   = 7'h19; // 0011001w
  localparam logic [6:0] OPC_XOR_ACC  = 7'h1a; // 0011010w
  localparam logic [6:0] OPC_TEST_RM  = 7'h42; // 1000010w
  localparam logic [6:0] OPC_TEST_ACC = 7'h54; // 1010100w
  localparam logic [6:0] OPC_GRP_IMM  = 7'h40; // 1000000w
  localparam logic [6:0] OPC_GRP_UN   = 7'h7b; // 1111011w
  localparam logic [6:0] OPC_SCMP     = 7'h53; // 1010011w
  localparam logic [6:0] OPC_PIN      = 7'h36; // 0110110w
  localparam logic [6:0] OPC_SLOAD    = 7'h56; // 1010110w
  localparam logic [6:0] OPC_SCOPY    = 7'h52; // 1010010w
  localparam logic [6:0] OPC_POUT     = 7'h37; // 0110111w
  localparam logic [6:0] OPC_SSCAN    = 7'h57; // 1010111w
  localparam logic [6:0] OPC_SSTORE   = 7'h55; // 1010101w
  localparam logic [7:0] PFX_REPEAT_WHILE_EQUAL     = 8'hf3; // 11110011

  // Second operand field values and register-mode encoding
  localparam logic [2:0] SEL_AND  = 3'h4;
  localparam logic [2:0] SEL_OR   = 3'h1;
  localparam logic [2:0] SEL_XOR  = 3'h6;
  localparam logic [2:0] SEL_TEST = 3'h0;
  localparam logic [2:0] SEL_NOT  = 3'h2;
  localparam logic [1:0] MOD_REG  = 2'h3;

  // Clock counts
  localparam int CLK_REG       = 2;
  localparam int CLK_RMW       = 7;
  localparam int CLK_LOAD      = 6;
  localparam int CLK_TEST_MEM  = 5;
  localparam int CLK_NOT_MEM   = 6;
  localparam int CLK_SCMP      = 10;
  localparam int CLK_PIN_FAST  = 9;
  localparam int CLK_PIN_SLOW  = 29;
  localparam int CLK_POUT_FAST = 8;
  localparam int CLK_SLOAD     = 5;
  localparam int CLK_SCOPY     = 7;
  localparam int CLK_SSCAN     = 7;
  localparam int CLK_SSTORE    = 4;
  localparam int CLK_REP_BASE  = 5;
  localparam int CLK_REP_EACH  = 9;

  // Data bus cycle counts
  localparam int DAT_NONE     = 0;
  localparam int DAT_ONE      = 1;
  localparam int DAT_TWO      = 2;
  localparam int DAT_REP_EACH = 2;

endpackage
`default_nettype wire

// ---- core/lsodt_timer.sv ----
`default_nettype none
// Holds busy for exactly the loaded number of clocks, then pulses done
module lsodt_timer
  #(parameter int TIME_W = 37)
  (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Load request
    input  wire logic              load,
    input  wire logic [TIME_W-1:0] clocks,
    // Status
    output var  logic              busy,
    output var  logic              done
  );

  logic [TIME_W-1:0] remain;

  // A counter needs at least one bit to hold a nonzero count
  if (TIME_W < 1)
    $error("lsodt_timer: TIME_W must be at least 1");

  // Remaining clocks of the running instruction
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      remain <= '0;
    else if (load)
      remain <= clocks;
    else if (busy)
      remain <= remain - TIME_W'(1);
  end

  // Busy spans the count; a zero count never raises it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      busy <= 1'b0;
    else if (load)
      busy <= (clocks != '0);
    else if (busy && remain == TIME_W'(1))
      busy <= 1'b0;
  end

  // One-cycle completion pulse after the last busy cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      done <= 1'b0;
    else
      done <= busy && !load && remain == TIME_W'(1);
  end

endmodule // lsodt_timer
`default_nettype wire

// ---- core/lsodt_decoder.sv ----
`default_nettype none
module lsodt_decoder
  import lsodt_pkg::*;
  #(
    parameter int CNT_W         = 32,
    parameter int CLK_POUT_SLOW = 28
  )
  (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Instruction request
    input  wire logic                 op_valid,
    input  wire logic                 rep_prefix,
    input  wire logic [7:0]           opcode,
    input  wire logic [7:0]           modrm,
    input  wire logic [CNT_W-1:0]     count_register,
    input  wire logic                 io_slow,
    // Decode answer
    output var  logic                 dec_valid,
    output var  logic                 dec_legal,
    output var  lsodt_op_t            op_class,
    output var  logic                 size_full,
    output var  logic                 mem_operand,
    output var  logic                 writes_result,
    output var  logic                 uses_acc,
    output var  logic [CNT_W+4:0]     clocks,
    output var  logic [CNT_W+1:0]     data_cycles,
    // Execution timing
    output logic                      busy,
    output logic                      done
  );

  localparam int TIME_W = CNT_W + 5;
  localparam int DATA_W = CNT_W + 2;

  // The repeat arithmetic is sized for at most a 32-bit count
  if (CNT_W < 1 || CNT_W > 32)
    $error("lsodt_decoder: CNT_W must lie in 1..32");
  if (CLK_POUT_SLOW < CLK_POUT_FAST)
    $error("lsodt_decoder: slow output count below fast count");

  // Widen a small constant to the clock field
  function automatic logic [TIME_W-1:0] tclk(input int v);
    return TIME_W'(v);
  endfunction

  // Widen a small constant to the data field
  function automatic logic [DATA_W-1:0] tdat(input int v);
    return DATA_W'(v);
  endfunction

  // First of a pair for a register operand, second for memory
  function automatic int pick(input logic reg_op, input int r, input int m);
    return reg_op ? r : m;
  endfunction

  lsodt_op_t         next_class;
  logic              next_legal;
  logic              next_mem;
  logic              next_write;
  logic              next_acc;
  logic [TIME_W-1:0] next_clocks;
  logic [DATA_W-1:0] next_data;
  logic [6:0]        op7;
  logic [2:0]        sel;
  logic              reg_op;
  logic              take;

  assign op7    = opcode[7:1];
  assign sel    = modrm[5:3];
  assign reg_op = (modrm[7:6] == MOD_REG);
  // New instructions are ignored while the previous one is timed
  assign take   = op_valid && !busy;

  // Opcode decode and timing lookup
  always_comb
  begin
    next_class  = OP_ILLEGAL;
    next_legal  = 1'b0;
    next_mem    = 1'b0;
    next_write  = 1'b0;
    next_acc    = 1'b0;
    next_clocks = '0;
    next_data   = '0;
    if (rep_prefix)
    begin
      // Only the repeated compare is decoded here; n comes from count
      if (op7 == OPC_SCMP)
      begin
        next_class  = OP_SCMP;
        next_legal  = 1'b1;
        next_mem    = 1'b1;
        next_clocks = tclk(CLK_REP_BASE)
                    + TIME_W'(count_register) * tclk(CLK_REP_EACH);
        next_data   = DATA_W'(count_register) * tdat(DAT_REP_EACH);
      end
    end
    else
    begin
      case (op7)
        OPC_AND_RM, OPC_OR_RM, OPC_XOR_RM:
        begin
          // Register form of 00xxx00w needs no bus at all
          next_legal  = 1'b1;
          next_write  = 1'b1;
          next_mem    = !reg_op;
          next_clocks = tclk(pick(reg_op, CLK_REG, CLK_RMW));
          next_data   = tdat(pick(reg_op, DAT_NONE, DAT_TWO));
        end
        OPC_AND_MR, OPC_OR_MR, OPC_XOR_MR:
        begin
          next_legal  = 1'b1;
          next_write  = 1'b1;
          next_mem    = !reg_op;
          next_clocks = tclk(pick(reg_op, CLK_REG, CLK_LOAD));
          next_data   = tdat(pick(reg_op, DAT_NONE, DAT_ONE));
        end
        OPC_AND_ACC, OPC_OR_ACC, OPC_XOR_ACC:
        begin
          next_legal  = 1'b1;
          next_write  = 1'b1;
          next_acc    = 1'b1;
          next_clocks = tclk(CLK_REG);
        end
        OPC_TEST_RM:
        begin
          // Flags only: result is never written back
          next_class  = OP_TEST;
          next_legal  = 1'b1;
          next_mem    = !reg_op;
          next_clocks = tclk(pick(reg_op, CLK_REG, CLK_TEST_MEM));
          next_data   = tdat(pick(reg_op, DAT_NONE, DAT_ONE));
        end
        OPC_TEST_ACC:
        begin
          next_class  = OP_TEST;
          next_legal  = 1'b1;
          next_acc    = 1'b1;
          next_clocks = tclk(CLK_REG);
        end
        OPC_GRP_IMM:
        begin
          // Immediate group: operation chosen by the second operand field
          next_mem    = !reg_op;
          next_clocks = tclk(pick(reg_op, CLK_REG, CLK_RMW));
          next_data   = tdat(pick(reg_op, DAT_NONE, DAT_TWO));
          next_write  = 1'b1;
          if (sel == SEL_AND || sel == SEL_OR || sel == SEL_XOR)
            next_legal = 1'b1;
        end
        OPC_GRP_UN:
        begin
          // Other fields of this group belong to other decoders
          next_mem = !reg_op;
          if (sel == SEL_TEST)
          begin
            next_class  = OP_TEST;
            next_legal  = 1'b1;
            next_clocks = tclk(pick(reg_op, CLK_REG, CLK_TEST_MEM));
            next_data   = tdat(pick(reg_op, DAT_NONE, DAT_ONE));
          end
          else if (sel == SEL_NOT)
          begin
            next_class  = OP_NOT;
            next_legal  = 1'b1;
            next_write  = 1'b1;
            next_clocks = tclk(pick(reg_op, CLK_REG, CLK_NOT_MEM));
            next_data   = tdat(pick(reg_op, DAT_NONE, DAT_TWO));
          end
        end
        OPC_SCMP:
        begin
          next_class  = OP_SCMP;
          next_legal  = 1'b1;
          next_mem    = 1'b1;
          next_clocks = tclk(CLK_SCMP);
          next_data   = tdat(DAT_TWO);
        end
        OPC_PIN:
        begin
          // Which condition applies is given by io_slow from outside
          next_class  = OP_PIN;
          next_legal  = 1'b1;
          next_mem    = 1'b1;
          next_write  = 1'b1;
          next_clocks = io_slow ? tclk(CLK_PIN_SLOW)
                                : tclk(CLK_PIN_FAST);
          next_data   = tdat(DAT_ONE);
        end
        OPC_SLOAD:
        begin
          next_class  = OP_SLOAD;
          next_legal  = 1'b1;
          next_mem    = 1'b1;
          next_write  = 1'b1;
          next_acc    = 1'b1;
          next_clocks = tclk(CLK_SLOAD);
          next_data   = tdat(DAT_ONE);
        end
        OPC_SCOPY:
        begin
          next_class  = OP_SCOPY;
          next_legal  = 1'b1;
          next_mem    = 1'b1;
          next_write  = 1'b1;
          next_clocks = tclk(CLK_SCOPY);
          next_data   = tdat(DAT_TWO);
        end
        OPC_POUT:
        begin
          // The slow count is a parameter, its condition an input
          next_class  = OP_POUT;
          next_legal  = 1'b1;
          next_mem    = 1'b1;
          next_clocks = io_slow ? tclk(CLK_POUT_SLOW)
                                : tclk(CLK_POUT_FAST);
          next_data   = tdat(DAT_ONE);
        end
        OPC_SSCAN:
        begin
          next_class  = OP_SSCAN;
          next_legal  = 1'b1;
          next_mem    = 1'b1;
          next_acc    = 1'b1;
          next_clocks = tclk(CLK_SSCAN);
          next_data   = tdat(DAT_ONE);
        end
        OPC_SSTORE:
        begin
          next_class  = OP_SSTORE;
          next_legal  = 1'b1;
          next_mem    = 1'b1;
          next_write  = 1'b1;
          next_acc    = 1'b1;
          next_clocks = tclk(CLK_SSTORE);
          next_data   = tdat(DAT_ONE);
        end
        default:
        begin
          next_legal = 1'b0;
        end
      endcase
      // Class of the three-way ALU opcodes follows the opcode family
      if (op7 == OPC_AND_RM || op7 == OPC_AND_MR || op7 == OPC_AND_ACC)
        next_class = OP_AND;
      else if (op7 == OPC_OR_RM || op7 == OPC_OR_MR || op7 == OPC_OR_ACC)
        next_class = OP_OR;
      else if (op7 == OPC_XOR_RM || op7 == OPC_XOR_MR
               || op7 == OPC_XOR_ACC)
        next_class = OP_XOR;
      else if (op7 == OPC_GRP_IMM)
      begin
        if (sel == SEL_AND)
          next_class = OP_AND;
        else if (sel == SEL_OR)
          next_class = OP_OR;
        else if (sel == SEL_XOR)
          next_class = OP_XOR;
      end
    end
    // Illegal codes report nothing but their refusal
    if (!next_legal)
    begin
      next_class  = OP_ILLEGAL;
      next_mem    = 1'b0;
      next_write  = 1'b0;
      next_acc    = 1'b0;
      next_clocks = '0;
      next_data   = '0;
    end
  end

  // One-cycle pulse marking a fresh decode answer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dec_valid <= 1'b0;
    else
      dec_valid <= take;
  end

  // Decode answer holds until the next accepted request
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dec_legal     <= 1'b0;
      op_class      <= OP_ILLEGAL;
      size_full     <= 1'b0;
      mem_operand   <= 1'b0;
      writes_result <= 1'b0;
      uses_acc      <= 1'b0;
      clocks        <= '0;
      data_cycles   <= '0;
    end
    else if (take)
    begin
      dec_legal     <= next_legal;
      op_class      <= next_class;
      size_full     <= next_legal && opcode[0];
      mem_operand   <= next_mem;
      writes_result <= next_write;
      uses_acc      <= next_acc;
      clocks        <= next_clocks;
      data_cycles   <= next_data;
    end
  end

  // Execution timer; only legal codes start it
  lsodt_timer #(.TIME_W(TIME_W)) u_timer (
    .clk    (clk),
    .rst_b  (rst_b),
    .load   (take && next_legal),
    .clocks (next_clocks),
    .busy   (busy),
    .done   (done)
  );

endmodule // lsodt_decoder
`default_nettype wire

// ---- bench/lsodt_busy_meter.sv ----
`default_nettype none
// Far-side execution meter: times each busy run, reports it at done
module lsodt_busy_meter
  #(parameter int CNT_W = 32)
  (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Execution status
    input  wire logic             busy,
    input  wire logic             done,
    // Measured run
    output var  logic             meas_valid,
    output var  logic [CNT_W+4:0] meas_len
  );
  timeunit 1ns;
  timeprecision 100ps;
  logic [CNT_W+4:0] run;
  // Cleared while idle so every run counts from zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      run <= '0;
    else if (busy)
      run <= run + 1'b1;
    else
      run <= '0;
  end
  // Length is handed over with the done pulse
  assign meas_valid = done;
  assign meas_len   = run;
endmodule // lsodt_busy_meter
`default_nettype wire

// ---- bench/lsodt_decoder_asserts.sv ----
`default_nettype none
// Decode and timing checks seen from the decoder ports only
module lsodt_decoder_asserts
  import lsodt_pkg::*;
  #(
    parameter int CNT_W         = 32,
    parameter int CLK_POUT_SLOW = 28
  )
  (
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst_b,
    // Request
    input wire logic             op_valid,
    input wire logic             rep_prefix,
    input wire logic [7:0]       opcode,
    input wire logic [7:0]       modrm,
    input wire logic [CNT_W-1:0] count_register,
    input wire logic             io_slow,
    // Answer and timing
    input wire logic             dec_valid,
    input wire logic             dec_legal,
    input wire lsodt_op_t        op_class,
    input wire logic             size_full,
    input wire logic             mem_operand,
    input wire logic             writes_result,
    input wire logic             uses_acc,
    input wire logic [CNT_W+4:0] clocks,
    input wire logic [CNT_W+1:0] data_cycles,
    input wire logic             busy,
    input wire logic             done
  );
  timeunit 1ns;
  timeprecision 100ps;
  logic             take;
  logic             one;
  logic [6:0]       opc;
  logic [CNT_W+4:0] run;
  // Helpers; one excludes the repeat prefix
  assign take = op_valid && !busy;
  assign one  = take && !rep_prefix;
  assign opc  = opcode[7:1];
  // Busy run length, to compare against the promised count at done
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      run <= '0;
    else if (busy)
      run <= run + 1'b1;
    else
      run <= '0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_short_and_two:
    assert property (one && opc == OPC_AND_ACC |=> busy [*2] ##1 done)
    else $error("short and not two clocks");
  a_flag_acc_form:
    assert property (one && opc == OPC_TEST_ACC |=>
      uses_acc && !writes_result && clocks == 2) else $error("flag acc");
  a_or_mem_cost:
    assert property (one && opc == OPC_OR_RM && modrm[7:6] != MOD_REG |=>
      mem_operand && clocks == 7 && data_cycles == 2) else $error("or mem");
  a_xor_reg_fast:
    assert property (one && opc == OPC_XOR_MR && modrm[7:6] == MOD_REG |=>
      !mem_operand && clocks == 2 && data_cycles == 0) else $error("xor");
  a_compare_once:
    assert property (one && opc == OPC_SCMP |=>
      clocks == 10 && data_cycles == 2) else $error("compare");
  a_repeat_count:
    assert property (take && rep_prefix && opc == OPC_SCMP |=>
      clocks == {5'h0, $past(count_register)} * 9 + 5 &&
      data_cycles == {1'b0, $past(count_register), 1'b0})
    else $error("repeat count");
  a_input_slow:
    assert property (one && opc == OPC_PIN && io_slow |=>
      clocks == 29 && data_cycles == 1) else $error("input slow");
  a_size_bit:
    assert property (take |=> size_full == (dec_legal && $past(opcode[0])))
    else $error("size flag");
  a_test_no_write:
    assert property (one && opc == OPC_TEST_RM |=>
      op_class == OP_TEST && !writes_result) else $error("flag only");
  a_busy_length:
    assert property (done |-> run == clocks) else $error("busy length");
  a_illegal_idle:
    assert property (dec_valid && !dec_legal && !op_valid |->
      !busy ##1 !busy && !done) else $error("illegal ran");
  c_repeat: cover property (take && rep_prefix);
  c_illegal: cover property (dec_valid && !dec_legal);
  c_refused: cover property (op_valid && busy);
endmodule // lsodt_decoder_asserts
bind lsodt_decoder lsodt_decoder_asserts
  #(.CNT_W(CNT_W), .CLK_POUT_SLOW(CLK_POUT_SLOW)) u_chk (
  .clk(clk), .rst_b(rst_b), .op_valid(op_valid), .rep_prefix(rep_prefix),
  .opcode(opcode), .modrm(modrm), .count_register(count_register),
  .io_slow(io_slow), .dec_valid(dec_valid), .dec_legal(dec_legal),
  .op_class(op_class), .size_full(size_full), .mem_operand(mem_operand),
  .writes_result(writes_result), .uses_acc(uses_acc), .clocks(clocks),
  .data_cycles(data_cycles), .busy(busy), .done(done));
`default_nettype wire

// ---- bench/lsodt_decoder_tb.sv ----
`default_nettype none
module lsodt_decoder_tb
  import lsodt_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [6:0] opc;
    logic [2:0] fld;
    lsodt_op_t  cls;
    int         cr, cm, dr, dm;
    logic       wr, acc;
    int         k;
  } lsodt_row_t;
  typedef struct {
    logic        lg;
    lsodt_op_t   cls;
    logic [36:0] ck;
    logic [33:0] dt;
    logic        wr, acc, mem, sz;
  } lsodt_exp_t;
  logic        clk, rst_b, op_valid, rep_prefix, io_slow;
  logic [7:0]  opcode, modrm;
  logic [31:0] count_register;
  logic        dec_valid, dec_legal, size_full, mem_operand;
  logic        writes_result, uses_acc, busy, done, meas_valid;
  lsodt_op_t   op_class;
  logic [36:0] clocks, meas_len;
  logic [33:0] data_cycles;
  int          error_cnt, n_tests, cyc;
  lsodt_row_t  rows[$];
  lsodt_exp_t  eq[$];
  logic [36:0] lq[$];

  lsodt_decoder DUT (.clk(clk), .rst_b(rst_b), .op_valid(op_valid),
    .rep_prefix(rep_prefix), .opcode(opcode), .modrm(modrm),
    .count_register(count_register), .io_slow(io_slow),
    .dec_valid(dec_valid), .dec_legal(dec_legal), .op_class(op_class),
    .size_full(size_full), .mem_operand(mem_operand),
    .writes_result(writes_result), .uses_acc(uses_acc), .clocks(clocks),
    .data_cycles(data_cycles), .busy(busy), .done(done));
  lsodt_busy_meter u_meter (.clk(clk), .rst_b(rst_b), .busy(busy),
    .done(done), .meas_valid(meas_valid), .meas_len(meas_len));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(logic [39:0] g, logic [39:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ad(logic [6:0] o, logic [2:0] f, lsodt_op_t c,
                    int cr, int cm, int dr, int dm, logic w, logic a, int k);
    rows.push_back('{o, f, c, cr, cm, dr, dm, w, a, k});
  endtask

  // Expected answer for a table row; pairs are register then memory
  function automatic lsodt_exp_t ex(lsodt_row_t r, logic m, logic sz,
                                    logic sl);
    logic mm;
    mm = m && r.k == 0;
    ex.lg = 1'b1;
    ex.cls = r.cls;
    ex.wr = r.wr;
    ex.acc = r.acc;
    ex.sz = sz;
    ex.mem = mm || r.k == 2;
    ex.ck = 37'(mm ? r.cm : r.cr);
    ex.dt = 34'(mm ? r.dm : r.dr);
    // Slow condition counts come from the constants, not an offset
    if (sl && r.cls == OP_PIN)
      ex.ck = 37'(CLK_PIN_SLOW);
    if (sl && r.cls == OP_POUT)
      ex.ck = 37'd28;
  endfunction

  // One request; hold keeps op_valid up while busy, which must be ignored
  task automatic issue(logic [7:0] opc, logic [7:0] mr, logic rep,
                       logic [31:0] n, logic sl, lsodt_exp_t e, int hold);
    int w;
    eq.push_back(e);
    if (e.lg)
      lq.push_back(e.ck);
    @(posedge clk);
    op_valid <= 1'b1;
    opcode <= opc;
    modrm <= mr;
    rep_prefix <= rep;
    count_register <= n;
    io_slow <= sl;
    @(posedge clk);
    op_valid <= (hold > 0);
    opcode <= ~opc;
    if (hold > 0)
    begin
      repeat (hold) @(posedge clk);
      op_valid <= 1'b0;
    end
    w = 0;
    do
    begin
      @(posedge clk);
      w++;
    end while (!(done || (dec_valid && !dec_legal)) && w < 500);
    if (w >= 500)
      error_cnt++;
  endtask

  // Takes the oldest note whenever an answer or a measured run appears
  always @(posedge clk)
  begin
    lsodt_exp_t x;
    if (rst_b && dec_valid)
    begin
      if (eq.size() == 0)
        cmp(40'h1, 40'h0);
      else
      begin
        x = eq.pop_front();
        cmp({dec_legal, op_class, writes_result, uses_acc, mem_operand,
             size_full}, {x.lg, x.cls, x.wr, x.acc, x.mem, x.sz});
        cmp(clocks, x.ck);
        cmp(data_cycles, x.dt);
      end
    end
    if (rst_b && meas_valid)
      cmp(meas_len, lq.size() ? lq.pop_front() : 37'h0);
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial
  begin
    lsodt_row_t  r;
    lsodt_exp_t  e;
    logic        sz, sl;
    logic [2:0]  f;
    logic [7:0]  bad_op[5], bad_mr[5];
    logic [31:0] n;
    clk = 1'b0;
    rst_b = 1'b0;
    op_valid = 1'b0;
    rep_prefix = 1'b0;
    opcode = 8'h00;
    modrm = 8'h00;
    count_register = 32'h0;
    io_slow = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(32'h9719));
    ad(OPC_AND_RM, 0, OP_AND, 2, 7, 0, 2, 1, 0, 0);
    ad(OPC_AND_MR, 0, OP_AND, 2, 6, 0, 1, 1, 0, 0);
    ad(OPC_GRP_IMM, SEL_AND, OP_AND, 2, 7, 0, 2, 1, 0, 0);
    ad(OPC_AND_ACC, 0, OP_AND, 2, 2, 0, 0, 1, 1, 1);
    ad(OPC_TEST_RM, 0, OP_TEST, 2, 5, 0, 1, 0, 0, 0);
    ad(OPC_GRP_UN, SEL_TEST, OP_TEST, 2, 5, 0, 1, 0, 0, 0);
    ad(OPC_TEST_ACC, 0, OP_TEST, 2, 2, 0, 0, 0, 1, 1);
    ad(OPC_OR_RM, 0, OP_OR, 2, 7, 0, 2, 1, 0, 0);
    ad(OPC_OR_MR, 0, OP_OR, 2, 6, 0, 1, 1, 0, 0);
    ad(OPC_GRP_IMM, SEL_OR, OP_OR, 2, 7, 0, 2, 1, 0, 0);
    ad(OPC_OR_ACC, 0, OP_OR, 2, 2, 0, 0, 1, 1, 1);
    ad(OPC_XOR_RM, 0, OP_XOR, 2, 7, 0, 2, 1, 0, 0);
    ad(OPC_XOR_MR, 0, OP_XOR, 2, 6, 0, 1, 1, 0, 0);
    ad(OPC_GRP_IMM, SEL_XOR, OP_XOR, 2, 7, 0, 2, 1, 0, 0);
    ad(OPC_XOR_ACC, 0, OP_XOR, 2, 2, 0, 0, 1, 1, 1);
    ad(OPC_GRP_UN, SEL_NOT, OP_NOT, 2, 6, 0, 2, 1, 0, 0);
    ad(OPC_SCMP, 0, OP_SCMP, 10, 10, 2, 2, 0, 0, 2);
    ad(OPC_PIN, 0, OP_PIN, 9, 9, 1, 1, 1, 0, 2);
    ad(OPC_SLOAD, 0, OP_SLOAD, 5, 5, 1, 1, 1, 1, 2);
    ad(OPC_SCOPY, 0, OP_SCOPY, 7, 7, 2, 2, 1, 0, 2);
    ad(OPC_POUT, 0, OP_POUT, 8, 8, 1, 1, 0, 0, 2);
    ad(OPC_SSCAN, 0, OP_SSCAN, 7, 7, 1, 1, 0, 1, 2);
    ad(OPC_SSTORE, 0, OP_SSTORE, 4, 4, 1, 1, 1, 1, 2);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    // Every form with register and memory operand, random size and slow
    foreach (rows[i])
      for (int m = 0; m < 2; m++)
      begin
        r = rows[i];
        sz = 1'($urandom);
        sl = 1'($urandom);
        f = (r.opc == OPC_GRP_IMM || r.opc == OPC_GRP_UN) ? r.fld
                                                          : 3'($urandom);
        e = ex(r, m[0], sz, sl);
        issue({r.opc, sz}, {m ? 2'($urandom % 3) : MOD_REG, f,
              3'($urandom)}, 1'b0, $urandom, sl, e, 1);
      end
    // Repeated compare, count zero and one as boundaries
    for (int j = 0; j < 3; j++)
    begin
      n = (j < 2) ? 32'(j) : 32'($urandom % 6 + 2);
      e = '{1'b1, OP_SCMP, 37'(5 + 9 * n), 34'(2 * n), 1'b0, 1'b0, 1'b1,
            1'b1};
      issue({OPC_SCMP, 1'b1}, 8'h00, 1'b1, n, 1'b0, e, 0);
    end
    // Undecoded codes back to back: answer only, no busy
    bad_op = '{{OPC_GRP_IMM, 1'b1}, {OPC_GRP_IMM, 1'b0},
               {OPC_GRP_UN, 1'b1}, {OPC_SLOAD, 1'b0}, 8'h0e};
    bad_mr = '{8'hd0, 8'h38, 8'h08, 8'h00, 8'h00};
    e = '{1'b0, OP_ILLEGAL, 37'h0, 34'h0, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int j = 0; j < 5; j++)
      issue(bad_op[j], bad_mr[j], j == 3, 32'h3, 1'b0, e, 0);
    repeat (4) @(posedge clk);
    cmp(32'(eq.size() + lq.size()), 32'h0);
    tally_and_finish();
  end
endmodule // lsodt_decoder_tb
`default_nettype wire
